// file: src/preset_divider_strap_decoder.sv
// strap decoder for preset divider values with apb override registers
// Functional notes
// - grounded strap reads zero, open strap reads one.
// - first strap field picks first reference preset, second field second.
// - third strap field picks feedback divider and first-output stage one; stage two is one for every code.
// - serial-port divider writes replace the strap presets.
// - either input field all ones selects the 19.44 MHz mode.
// - second output divider is one unless programmed.
// - input codes zero to fourteen give fixed integer parts.
// - each input preset gives a modulus value.
// - each input preset gives a signed fraction.
// - every output code gives feedback integer, modulus and fraction.
// - output code all ones is an ordinary preset, integer 149.
// - first output stages are 6/1 for codes 0-10, 5/1 above.
// - strap decode stays the default; writes only override.
`include "preset_divider_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module preset_divider_strap_decoder
(
  // clock and reset
  input  wire logic                              ref_clk_i,
  input  wire logic                              srst_i,
  // strap pins, open reads high
  input  wire logic [3:0]                        first_ref_strap_i,
  input  wire logic [3:0]                        second_ref_strap_i,
  input  wire logic [3:0]                        output_strap_i,
  // apb slave
  input  wire logic [11:0]                       paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // divider values
  output preset_divider_pkg::div_preset_t        first_reference_input_div_o,
  output preset_divider_pkg::div_preset_t        second_reference_input_div_o,
  output preset_divider_pkg::div_preset_t        feedback_div_o,
  output logic      [7:0]                        first_output_stage_one_divider_o,
  output logic      [7:0]                        first_output_stage_two_divider_o,
  output logic      [7:0]                        second_output_divider_o,
  output logic                                   mode_1944_o
);
  import preset_divider_pkg::*;

  logic        [3:0]     meta_a;
  logic        [3:0]     meta_b;
  logic        [3:0]     meta_y;
  logic        [3:0]     sync_a;
  logic        [3:0]     sync_b;
  logic        [3:0]     sync_y;
  logic        [`OVR_W-1:0] ovr_en;
  logic        [`OVR_W-1:0] next_ovr_en;
  div_preset_t           a_val;
  div_preset_t           b_val;
  div_preset_t           fb_val;
  div_preset_t           next_a_val;
  div_preset_t           next_b_val;
  div_preset_t           next_fb_val;
  logic        [7:0]     p0_val;
  logic        [7:0]     p1_val;
  logic        [7:0]     p2_val;
  logic        [7:0]     next_p0_val;
  logic        [7:0]     next_p1_val;
  logic        [7:0]     next_p2_val;
  div_preset_t           eff_a;
  div_preset_t           eff_b;
  out_preset_t           eff_out;
  logic        [7:0]     eff_p2;
  logic                  next_mode;
  logic                  apb_wr;

  // shared input lookup; the all-ones code has no divider preset
  function automatic div_preset_t in_lookup(input logic [3:0] code);
    div_preset_t r;
    case (code)
      4'h0: r = '{8'h17, 20'h1fbd0, 20'sh1b0d0};
      4'h1: r = '{8'h18, 20'h1fbd0, -20'sh1d4c0};
      4'h2: r = '{8'h18, 20'h259c2, -20'sh1bfa2};
      4'h3: r = '{8'h18, 20'h1fbd0, 20'sh0b090};
      4'h4: r = '{8'h18, 20'h28a00, 20'sh17890};
      4'h5: r = '{8'h19, 20'h19640, -20'sh0ae51};
      4'h6: r = '{8'h19, 20'h30580, -20'sh0a78b};
      4'h7: r = '{8'h19, 20'h25c4c, 20'sh0a35c};
      4'h8: r = '{8'h19, 20'h259c2, 20'sh124da};
      4'h9: r = '{8'h19, 20'h2c6f0, 20'sh16b48};
      4'ha: r = '{8'h19, 20'h25738, 20'sh1a658};
      4'hb: r = '{8'h1a, 20'h30240, 20'sh1099e};
      4'hc: r = '{8'h1a, 20'h23dd4, 20'sh1469c};
      4'hd: r = '{8'h1b, 20'h30580, -20'sh277db};
      4'he: r = '{8'h1b, 20'h30240, -20'sh1c51b};
      default: r = '{8'h00, 20'h00000, 20'sh00000};
    endcase
    return r;
  endfunction

  // output lookup; every code is a plain preset
  function automatic out_preset_t out_lookup(input logic [3:0] code);
    out_preset_t r;
    case (code)
      4'h0: r.fb = '{8'h8f, 20'h7ef40, 20'sh46b40};
      4'h1: r.fb = '{8'h90, 20'h7ef40, 20'sh1d4c0};
      4'h2: r.fb = '{8'h90, 20'h4b384, 20'sh39cc0};
      4'h3: r.fb = '{8'h94, 20'h7ef40, 20'sh05780};
      4'h4: r.fb = '{8'h94, 20'h71c00, 20'sh53f20};
      4'h5: r.fb = '{8'h97, 20'h7ef40, 20'sh5a7c1};
      4'h6: r.fb = '{8'h98, 20'h71c00, 20'sh27d58};
      4'h7: r.fb = '{8'h99, 20'h71c00, 20'sh5c400};
      4'h8: r.fb = '{8'h9a, 20'h503c0, 20'sh24e80};
      4'h9: r.fb = '{8'h9a, 20'h70540, 20'sh3bde0};
      4'ha: r.fb = '{8'h9b, 20'h77d80, 20'sh0db80};
      4'hb: r.fb = '{8'h85, 20'h503c0, 20'sh1d0dd};
      4'hc: r.fb = '{8'h85, 20'h72c40, 20'sh69ec0};
      4'hd: r.fb = '{8'h87, 20'h55500, 20'sh270e7};
      4'he: r.fb = '{8'h88, 20'h60480, 20'sh02d39};
      default: r.fb = '{8'h95, 20'h7ef40, 20'sh445c0};
    endcase
    r.stage_one = (code >= `FIRST_CLOCK_OUTPUT_FIVE_FIRST) ? `STAGE_FIVE : `STAGE_SIX;
    r.stage_two = `DIV_UNITY;
    return r;
  endfunction

  function automatic logic [31:0] sext(input logic signed [19:0] v);
    return {{12{v[19]}}, v};
  endfunction

  assign apb_wr  = psel && penable && pwrite;
  assign pready  = 1'b1;

  always_comb
  begin
    // pins already read open as one and ground as zero
    eff_a = ovr_en[`OVR_A] ? a_val : in_lookup(sync_a);
    eff_b = ovr_en[`OVR_B] ? b_val : in_lookup(sync_b);
    eff_out = out_lookup(sync_y);
    if (ovr_en[`OVR_FB])
    begin
      eff_out.fb = fb_val;
    end
    if (ovr_en[`OVR_FIRST_CLOCK_OUTPUT])
    begin
      eff_out.stage_one = p0_val;
      eff_out.stage_two = p1_val;
    end
    eff_p2 = ovr_en[`OVR_SECOND_CLOCK_OUTPUT] ? p2_val : `DIV_UNITY;
    next_mode = (sync_a == `STRAP_SPECIAL) ||
                (sync_b == `STRAP_SPECIAL);
    next_ovr_en = ovr_en;
    next_a_val  = a_val;
    next_b_val  = b_val;
    next_fb_val = fb_val;
    next_p0_val = p0_val;
    next_p1_val = p1_val;
    next_p2_val = p2_val;
    // a field write starts from the value now in force
    if (apb_wr)
    begin
      case (paddr)
        `ADDR_OVR_EN:
        begin
          next_ovr_en = pwdata[`OVR_W-1:0];
        end
        `ADDR_A_INT, `ADDR_A_MOD, `ADDR_A_FRAC:
        begin
          next_a_val = eff_a;
          next_ovr_en[`OVR_A] = 1'b1;
          if (paddr == `ADDR_A_INT) next_a_val.n = pwdata[7:0];
          else if (paddr == `ADDR_A_MOD) next_a_val.modulus = pwdata[19:0];
          else next_a_val.frac = pwdata[19:0];
        end
        `ADDR_B_INT, `ADDR_B_MOD, `ADDR_B_FRAC:
        begin
          next_b_val = eff_b;
          next_ovr_en[`OVR_B] = 1'b1;
          if (paddr == `ADDR_B_INT) next_b_val.n = pwdata[7:0];
          else if (paddr == `ADDR_B_MOD) next_b_val.modulus = pwdata[19:0];
          else next_b_val.frac = pwdata[19:0];
        end
        `ADDR_FB_INT, `ADDR_FB_MOD, `ADDR_FB_FRAC:
        begin
          next_fb_val = eff_out.fb;
          next_ovr_en[`OVR_FB] = 1'b1;
          if (paddr == `ADDR_FB_INT) next_fb_val.n = pwdata[7:0];
          else if (paddr == `ADDR_FB_MOD) next_fb_val.modulus = pwdata[19:0];
          else next_fb_val.frac = pwdata[19:0];
        end
        `ADDR_OUT_DIV:
        begin
          next_p0_val = pwdata[`DIV_P0_LSB +: 8];
          next_p1_val = pwdata[`DIV_P1_LSB +: 8];
          next_p2_val = pwdata[`DIV_P2_LSB +: 8];
          next_ovr_en[`OVR_FIRST_CLOCK_OUTPUT] = 1'b1;
          next_ovr_en[`OVR_SECOND_CLOCK_OUTPUT] = 1'b1;
        end
        default:
        begin
          next_ovr_en = ovr_en;
        end
      endcase
    end
  end

  // read side shows the registered divider outputs and strap state
  always_comb
  begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      `ADDR_STATUS:
      begin
        prdata[`STS_A_LSB +: 4]  = sync_a;
        prdata[`STS_B_LSB +: 4]  = sync_b;
        prdata[`STS_Y_LSB +: 4]  = sync_y;
        prdata[`STS_MODE_BIT]    = mode_1944_o;
      end
      `ADDR_OVR_EN:  prdata[`OVR_W-1:0] = ovr_en;
      `ADDR_A_INT:   prdata[7:0]  = first_reference_input_div_o.n;
      `ADDR_A_MOD:   prdata[19:0] = first_reference_input_div_o.modulus;
      `ADDR_A_FRAC:  prdata = sext(first_reference_input_div_o.frac);
      `ADDR_B_INT:   prdata[7:0]  = second_reference_input_div_o.n;
      `ADDR_B_MOD:   prdata[19:0] = second_reference_input_div_o.modulus;
      `ADDR_B_FRAC:  prdata = sext(second_reference_input_div_o.frac);
      `ADDR_FB_INT:  prdata[7:0]  = feedback_div_o.n;
      `ADDR_FB_MOD:  prdata[19:0] = feedback_div_o.modulus;
      `ADDR_FB_FRAC: prdata = sext(feedback_div_o.frac);
      `ADDR_OUT_DIV:
      begin
        prdata[`DIV_P0_LSB +: 8] = first_output_stage_one_divider_o;
        prdata[`DIV_P1_LSB +: 8] = first_output_stage_two_divider_o;
        prdata[`DIV_P2_LSB +: 8] = second_output_divider_o;
      end
      default:
      begin
        pslverr = psel && penable;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      meta_a  <= `STRAP_RESET;
      meta_b  <= `STRAP_RESET;
      meta_y  <= `STRAP_RESET;
      sync_a  <= `STRAP_RESET;
      sync_b  <= `STRAP_RESET;
      sync_y  <= `STRAP_RESET;
      ovr_en  <= `OVR_RESET;
      a_val   <= '0;
      b_val   <= '0;
      fb_val  <= '0;
      p0_val  <= `DIV_RESET;
      p1_val  <= `DIV_RESET;
      p2_val  <= `DIV_UNITY;
      first_reference_input_div_o      <= '0;
      second_reference_input_div_o     <= '0;
      feedback_div_o                   <= '0;
      first_output_stage_one_divider_o <= `DIV_RESET;
      first_output_stage_two_divider_o <= `DIV_RESET;
      second_output_divider_o          <= `DIV_UNITY;
      mode_1944_o                      <= 1'b0;
    end
    else
    begin
      meta_a  <= first_ref_strap_i;
      meta_b  <= second_ref_strap_i;
      meta_y  <= output_strap_i;
      sync_a  <= meta_a;
      sync_b  <= meta_b;
      sync_y  <= meta_y;
      ovr_en  <= next_ovr_en;
      a_val   <= next_a_val;
      b_val   <= next_b_val;
      fb_val  <= next_fb_val;
      p0_val  <= next_p0_val;
      p1_val  <= next_p1_val;
      p2_val  <= next_p2_val;
      first_reference_input_div_o      <= eff_a;
      second_reference_input_div_o     <= eff_b;
      feedback_div_o                   <= eff_out.fb;
      first_output_stage_one_divider_o <= eff_out.stage_one;
      first_output_stage_two_divider_o <= eff_out.stage_two;
      second_output_divider_o          <= eff_p2;
      mode_1944_o                      <= next_mode;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence a_int_write;
    apb_wr && paddr == `ADDR_A_INT;
  endsequence

  sequence quiet_bus;
    !apb_wr;
  endsequence

  strap_sync_a: assert property (
    !$past(srst_i) && !$past(srst_i, 2) |-> sync_y == $past(output_strap_i, 2))
    else $error("strap not passed through two flops");

  mode_flag_a: assert property (
    mode_1944_o == ($past(sync_a) == `STRAP_SPECIAL ||
                    $past(sync_b) == `STRAP_SPECIAL))
    else $error("special mode flag wrong");

  ovr_reset_a: assert property (
    $past(srst_i) |-> ovr_en == `OVR_RESET)
    else $error("override flags not cleared by reset");

  second_clock_output_unity_a: assert property (
    !$past(ovr_en[`OVR_SECOND_CLOCK_OUTPUT]) |-> second_output_divider_o == `DIV_UNITY)
    else $error("second output divider not unity");

  stage_pair_a: assert property (
    !$past(srst_i) && !$past(ovr_en[`OVR_FIRST_CLOCK_OUTPUT]) |->
      first_output_stage_one_divider_o ==
        (($past(sync_y) >= `FIRST_CLOCK_OUTPUT_FIVE_FIRST) ? `STAGE_FIVE : `STAGE_SIX)
      && first_output_stage_two_divider_o == `DIV_UNITY)
    else $error("first output stage default wrong");

  strap_default_a: assert property (
    !$past(srst_i) && !$past(ovr_en[`OVR_B]) |->
      second_reference_input_div_o == in_lookup($past(sync_b)))
    else $error("second reference preset not from straps");

  code_zero_a: assert property (
    !$past(srst_i) && !$past(ovr_en[`OVR_A]) &&
    $past(sync_a) == `STRAP_RESET |->
      first_reference_input_div_o.n == 8'h17 &&
      first_reference_input_div_o.modulus == 20'h1fbd0 &&
      first_reference_input_div_o.frac == 20'sh1b0d0)
    else $error("input code zero preset wrong");

  fb_top_code_a: assert property (
    !$past(srst_i) && !$past(ovr_en[`OVR_FB]) &&
    $past(sync_y) == `STRAP_SPECIAL |->
      feedback_div_o.n == 8'h95 && feedback_div_o.frac == 20'sh445c0)
    else $error("output code all ones preset wrong");

  override_a: assert property (
    a_int_write ##1 quiet_bus |->
      ovr_en[`OVR_A] ##1
      first_reference_input_div_o.n == $past(pwdata[7:0], 2))
    else $error("serial write did not override preset");

endmodule

`default_nettype wire

// file: src/preset_divider_regs.svh
// register offsets, field positions, reset values and strap codes
`ifndef PRESET_DIVIDER_REGS_SVH
`define PRESET_DIVIDER_REGS_SVH

`define ADDR_STATUS      12'h000
`define ADDR_OVR_EN      12'h004
`define ADDR_A_INT       12'h008
`define ADDR_A_MOD       12'h00c
`define ADDR_A_FRAC      12'h010
`define ADDR_B_INT       12'h014
`define ADDR_B_MOD       12'h018
`define ADDR_B_FRAC      12'h01c
`define ADDR_FB_INT      12'h020
`define ADDR_FB_MOD      12'h024
`define ADDR_FB_FRAC     12'h028
`define ADDR_OUT_DIV     12'h02c

`define OVR_A            0
`define OVR_B            1
`define OVR_FB           2
`define OVR_FIRST_CLOCK_OUTPUT         3
`define OVR_SECOND_CLOCK_OUTPUT         4
`define OVR_W            5
`define OVR_RESET        5'h00

`define STRAP_SPECIAL    4'hf
`define STRAP_RESET      4'h0
`define FIRST_CLOCK_OUTPUT_FIVE_FIRST  4'hb
`define STAGE_SIX        8'h06
`define STAGE_FIVE       8'h05
`define DIV_UNITY        8'h01
`define DIV_RESET        8'h00

`define STS_A_LSB        0
`define STS_B_LSB        4
`define STS_Y_LSB        8
`define STS_MODE_BIT     12
`define DIV_P0_LSB       0
`define DIV_P1_LSB       8
`define DIV_P2_LSB       16

`endif

// file: src/preset_divider_pkg.sv
// types shared by the strap decoder and its users
package preset_divider_pkg;

  typedef struct packed
  {
    logic        [7:0]  n;
    logic        [19:0] modulus;
    logic signed [19:0] frac;
  } div_preset_t;

  typedef struct packed
  {
    div_preset_t fb;
    logic [7:0]  stage_one;
    logic [7:0]  stage_two;
  } out_preset_t;

endpackage

// file: dv/strap_board.sv
// board strap wiring model: grounded pins read low, open pins read high
`timescale 1ns/100ps
`default_nettype none

module strap_board
(
  // grounded pin mask, one bit a strap pin
  input  wire logic [11:0] gnd_mask_i,
  // strap fields seen by the decoder
  output logic      [11:0] strap_o
);
  assign strap_o = ~gnd_mask_i;
endmodule

`default_nettype wire

// file: dv/preset_divider_strap_decoder_tb_top.sv
// self-checking bench for the preset divider strap decoder
`include "preset_divider_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module preset_divider_strap_decoder_tb_top;
  import preset_divider_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic [11:0] gnd_mask  = 12'h000;
  logic [11:0] strap;
  logic [11:0] paddr     = 12'h000;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  div_preset_t ref_a;
  div_preset_t ref_b;
  div_preset_t fb;
  logic [7:0]  st1;
  logic [7:0]  st2;
  logic [7:0]  second_clock_output;
  logic        mode;
  logic [31:0] rd;
  logic        er;
  int          err_total  = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  int in_n[15] = '{23, 24, 24, 24, 24, 25, 25, 25, 25, 25, 25, 26, 26, 27, 27};
  int in_m[15] = '{130000, 130000, 154050, 130000, 166400, 104000, 198016,
    154700, 154050, 182000, 153400, 197184, 146900, 198016, 197184};
  int in_f[15] = '{110800, -120000, -114594, 45200, 96400, -44625, -42891,
    41820, 74970, 93000, 108120, 67998, 83612, -161755, -115995};
  int fb_n[16] = '{143, 144, 144, 148, 148, 151, 152, 153, 154, 154, 155,
    133, 133, 135, 136, 149};
  int fb_m[16] = '{520000, 520000, 308100, 520000, 465920, 520000, 465920,
    465920, 328640, 460096, 490880, 328640, 470080, 349440, 394368, 520000};
  int fb_f[16] = '{289600, 120000, 236736, 22400, 343840, 370625, 163160,
    377856, 151168, 245216, 56192, 119005, 433856, 159975, 11577, 280000};

  strap_board board_u (.gnd_mask_i(gnd_mask), .strap_o(strap));

  preset_divider_strap_decoder dut_u
  (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .first_ref_strap_i(strap[3:0]), .second_ref_strap_i(strap[7:4]),
    .output_strap_i(strap[11:8]), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .first_reference_input_div_o(ref_a), .second_reference_input_div_o(ref_b),
    .feedback_div_o(fb), .first_output_stage_one_divider_o(st1),
    .first_output_stage_two_divider_o(st2), .second_output_divider_o(second_clock_output),
    .mode_1944_o(mode)
  );

  always #10 ref_clk_i = ~ref_clk_i;

  function automatic div_preset_t mk(input int n, input int m, input int f);
    mk.n = n[7:0];
    mk.modulus = m[19:0];
    mk.frac = f[19:0];
  endfunction

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [47:0] exp,
                     input logic [47:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk_i);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    @(posedge ref_clk_i);
    while (pready !== 1'b1)
    begin
      @(posedge ref_clk_i);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  task automatic set_straps(input int a, input int b, input int y);
    @(posedge ref_clk_i);
    gnd_mask <= ~{y[3:0], b[3:0], a[3:0]};
    settle();
  endtask

  task automatic test_inputs;
    for (int i = 0; i < 15; i++)
    begin
      set_straps(i, 14 - i, 0);
      chk("first ref", mk(in_n[i], in_m[i], in_f[i]), ref_a);
      chk("second ref", mk(in_n[14-i], in_m[14-i], in_f[14-i]), ref_b);
      chk("mode", 48'h0, mode);
    end
  endtask

  task automatic test_outputs;
    for (int y = 0; y < 16; y++)
    begin
      set_straps(0, 0, y);
      chk("feedback", mk(fb_n[y], fb_m[y], fb_f[y]), fb);
      chk("stage one", (y < 11) ? 48'h6 : 48'h5, st1);
      chk("stage two", 48'h1, st2);
      chk("second_clock_output div", 48'h1, second_clock_output);
    end
  endtask

  task automatic test_mode;
    set_straps(15, 0, 0);
    chk("mode a", 48'h1, mode);
    apb(`ADDR_STATUS, 1'b0, 32'h0);
    chk("status", 48'h100f, rd);
    set_straps(0, 15, 0);
    chk("mode b", 48'h1, mode);
    set_straps(14, 14, 15);
    chk("mode off", 48'h0, mode);
  endtask

  task automatic test_override;
    set_straps(1, 2, 3);
    apb(`ADDR_A_INT, 1'b1, 32'h3f);
    apb(`ADDR_A_FRAC, 1'b1, 32'hffffb);
    settle();
    chk("a override", mk(63, in_m[1], -5), ref_a);
    chk("b kept", mk(in_n[2], in_m[2], in_f[2]), ref_b);
    apb(`ADDR_A_FRAC, 1'b0, 32'h0);
    chk("frac read", 48'hfffffffb, rd);
    apb(`ADDR_OUT_DIV, 1'b1, 32'h030204);
    settle();
    chk("out div", 48'h030204, {second_clock_output, st2, st1});
    apb(12'h030, 1'b0, 32'h0);
    chk("unmapped err", 48'h1, er);
    chk("unmapped data", 48'h0, rd);
    set_straps(4, 2, 3);
    chk("a held", mk(63, in_m[1], -5), ref_a);
    apb(`ADDR_OVR_EN, 1'b1, 32'h0);
    settle();
    chk("a strap", mk(in_n[4], in_m[4], in_f[4]), ref_a);
    chk("second_clock_output strap", 48'h1, second_clock_output);
  endtask

  task automatic test_reset;
    apb(`ADDR_OUT_DIV, 1'b1, 32'h070809);
    apb(`ADDR_B_INT, 1'b1, 32'h11);
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    @(posedge ref_clk_i);
    srst_i <= 1'b0;
    settle();
    chk("second_clock_output reset", 48'h1, second_clock_output);
    chk("stage reset", 48'h6, st1);
    chk("b reset", mk(in_n[2], in_m[2], in_f[2]), ref_b);
  endtask

  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    test_inputs();
    test_outputs();
    test_mode();
    test_override();
    test_reset();
    complete_run();
  end
endmodule

`default_nettype wire
